// >>> pio_ports.sv
// Parallel port block: latches, direction, drive options and APB access.
// Assumes pins are sampled synchronously to pclk; pads resolve oe/out outside.
`timescale 1ns/1ps
module pio_ports
    import pio_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins
    input wire logic [PIO_NP-1:0][PIO_W-1:0] pin_in,
    output pio_pad_s [PIO_NP-1:0] pad,
    // Alternate functions
    input wire logic [PIO_NP-1:0][PIO_W-1:0] alt_out,
    input wire logic [PIO_NP-1:0][PIO_W-1:0] alt_oe,
    output logic [PIO_NP-1:0][PIO_W-1:0] alt_in,
    // Pad configuration
    output logic [PIO_NP-1:0][PIO_W-1:0] pad_driver_shape_ctrl,
    output logic [PIO_NP-1:0][PIO_W-1:0] thr_cmos,
    // Reset indication
    input wire logic rst_req,
    output logic reset_indication_out,
    output logic reset_indication_oe
);
    // Register state per port
    pio_word_t lat_r [PIO_NP], lat_nxt [PIO_NP]; // Output latches
    pio_word_t dir_r [PIO_NP], dir_nxt [PIO_NP]; // 1 = output
    pio_word_t od_r [PIO_NP], od_nxt [PIO_NP];   // 1 = open drain
    pio_word_t alt_r [PIO_NP], alt_nxt [PIO_NP]; // 1 = alternate function
    pio_word_t drv_r [PIO_NP], drv_nxt [PIO_NP]; // Pad shape/strength
    logic [1:0] thr_r [PIO_NP], thr_nxt [PIO_NP]; // Per-byte threshold
    // Registered outputs
    pio_pad_s [PIO_NP-1:0] pad_r, pad_nxt;
    logic [PIO_NP-1:0][PIO_W-1:0] ain_r, ain_nxt;
    logic [31:0] rd_r, rd_nxt;
    logic rsti_r, rsti_nxt;
    // Decode
    pio_idx_t port;
    logic [4:0] off;
    logic hit, wr_en, rd_setup;

    // Address decode; unmapped windows answer with an error
    always_comb begin
        port = paddr[PIO_PORT_LSB +: 3];
        off = paddr[4:0];
        hit = (port < pio_idx_t'(PIO_NP)) && (off[1:0] == 2'h0);
        wr_en = psel && penable && pwrite && hit;
        rd_setup = psel && !penable && !pwrite;
    end

    // Slave always ready; zero wait states
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata = rd_r;

    // Register next values
    always_comb begin
        pio_word_t w;
        w = pwdata[PIO_W-1:0];
        for (int p = 0; p < PIO_NP; p++) begin
            lat_nxt[p] = lat_r[p];
            dir_nxt[p] = dir_r[p];
            od_nxt[p] = od_r[p];
            alt_nxt[p] = alt_r[p];
            drv_nxt[p] = drv_r[p];
            thr_nxt[p] = thr_r[p];
            if (wr_en && port == pio_idx_t'(p)) begin
                unique case (off)
                    PIO_OFF_DATA: lat_nxt[p] = w & PIO_MASK[p];
                    PIO_OFF_SET: lat_nxt[p] = lat_r[p] | (w & PIO_MASK[p]);
                    PIO_OFF_CLR: lat_nxt[p] = lat_r[p] & ~w;
                    PIO_OFF_DIR: if (PIO_CAP[p].io) begin
                        dir_nxt[p] = w & PIO_MASK[p];
                    end
                    PIO_OFF_OD: if (PIO_CAP[p].od) begin
                        od_nxt[p] = w & PIO_MASK[p];
                    end
                    PIO_OFF_ALT: alt_nxt[p] = w & PIO_MASK[p];
                    PIO_OFF_THR: if (PIO_CAP[p].thr) begin
                        thr_nxt[p] = w[1:0];
                    end
                    PIO_OFF_DRV: if (PIO_CAP[p].drv) begin
                        drv_nxt[p] = w;
                    end
                    default: ; // Misaligned offsets already refused
                endcase
            end
        end
    end

    // Pad drive, input sampling and read data
    always_comb begin
        pio_word_t edir, eval;
        edir = '0;
        eval = '0;
        rd_nxt = rd_r;
        for (int p = 0; p < PIO_NP; p++) begin
            edir = (alt_r[p] & alt_oe[p]) | (~alt_r[p] & dir_r[p]);
            eval = (alt_r[p] & alt_out[p]) | (~alt_r[p] & lat_r[p]);
            edir = PIO_CAP[p].io ? (edir & PIO_MASK[p]) : '0;
            // input floats; open drain drives only low
            pad_nxt[p].oe = edir & ~(od_r[p] & eval);
            pad_nxt[p].out = eval & ~od_r[p] & edir;
            ain_nxt[p] = pin_in[p] & PIO_MASK[p];
        end
        if (rd_setup) begin
            rd_nxt = '0;
            if (hit) begin
                unique case (off)
                    PIO_OFF_DATA, PIO_OFF_SET, PIO_OFF_CLR:
                        rd_nxt[PIO_W-1:0] = pio_rd_mux(dir_r[port], pin_in[port], lat_r[port]) & PIO_MASK[port];
                    PIO_OFF_DIR: rd_nxt[PIO_W-1:0] = dir_r[port];
                    PIO_OFF_OD: rd_nxt[PIO_W-1:0] = od_r[port];
                    PIO_OFF_ALT: rd_nxt[PIO_W-1:0] = alt_r[port];
                    PIO_OFF_THR: rd_nxt[1:0] = thr_r[port];
                    PIO_OFF_DRV: rd_nxt[PIO_W-1:0] = drv_r[port];
                    default: rd_nxt = '0;
                endcase
            end
        end
        // Low while an internal reset is requested
        rsti_nxt = !rst_req;
    end

    // State registers
    // reset clears every enable, pins become inputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int p = 0; p < PIO_NP; p++) begin
                lat_r[p] <= PIO_RST_WORD;
                dir_r[p] <= PIO_RST_WORD;
                od_r[p] <= PIO_RST_WORD;
                alt_r[p] <= PIO_RST_WORD;
                drv_r[p] <= PIO_RST_WORD;
                thr_r[p] <= PIO_RST_THR;
            end
            pad_r <= '0;
            ain_r <= '0;
            rd_r <= '0;
            rsti_r <= 1'b0;
        end else begin
            lat_r <= lat_nxt;
            dir_r <= dir_nxt;
            od_r <= od_nxt;
            alt_r <= alt_nxt;
            drv_r <= drv_nxt;
            thr_r <= thr_nxt;
            pad_r <= pad_nxt;
            ain_r <= ain_nxt;
            rd_r <= rd_nxt;
            rsti_r <= rsti_nxt;
        end
    end

    // Outputs from flops
    always_comb begin
        for (int p = 0; p < PIO_NP; p++) begin
            pad_driver_shape_ctrl[p] = drv_r[p];
            thr_cmos[p] = pio_thr_lines(thr_r[p]) & PIO_MASK[p];
        end
    end
    assign pad = pad_r;
    assign alt_in = ain_r;
    // reset indication keeps driving through reset
    assign reset_indication_out = rsti_r;
    assign reset_indication_oe = 1'b1;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Write into one window, one cycle later
    sequence set_wr_s;
        wr_en && off == PIO_OFF_SET;
    endsequence
    sequence clr_wr_s;
        wr_en && off == PIO_OFF_CLR;
    endsequence

    bit_set_only_a: assert property (set_wr_s |=> lat_r[$past(port)] ==
        ($past(lat_r[port]) | ($past(pwdata[PIO_W-1:0]) & PIO_MASK[$past(port)])))
        else $error("set write touched other lines");
    bit_clr_only_a: assert property (clr_wr_s |=> lat_r[$past(port)] ==
        ($past(lat_r[port]) & ~$past(pwdata[PIO_W-1:0])))
        else $error("clear write touched other lines");
    dir_write_a: assert property (wr_en && off == PIO_OFF_DIR && port != PIO_IN_PORT
        |=> dir_r[$past(port)] == ($past(pwdata[PIO_W-1:0]) & PIO_MASK[$past(port)]))
        else $error("direction write lost");
    rst_ind_a: assert property (rst_req |=> !reset_indication_out && reset_indication_oe)
        else $error("reset indication not driven low");
    in_port_quiet_a: assert property (pad[PIO_IN_PORT].oe == '0 &&
        pad_driver_shape_ctrl[PIO_IN_PORT] == '0 && thr_cmos[PIO_IN_PORT] == '0)
        else $error("input-only port has drive or config");
    bus_port_plain_a: assert property (od_r[0] == '0 && thr_r[0] == 2'h0 &&
        od_r[1] == '0 && thr_r[1] == 2'h0)
        else $error("bus port got open drain or threshold");
    drv_apply_a: assert property (wr_en && off == PIO_OFF_DRV && PIO_CAP[port].drv
        |=> ##1 pad_driver_shape_ctrl[$past(port, 2)] == $past(pwdata[PIO_W-1:0], 2))
        else $error("driver setting not applied");
    rd_view_a: assert property (rd_setup && hit && off == PIO_OFF_DATA
        |=> prdata[PIO_W-1:0] == (pio_rd_mux($past(dir_r[port]), $past(pin_in[port]),
        $past(lat_r[port])) & PIO_MASK[$past(port)]))
        else $error("data read view wrong");
    line_count_a: assert property ((pad[6].oe & ~PIO_MASK[6]) == '0 &&
        (pad[5].oe & ~PIO_MASK[5]) == '0 && (pad[2].oe & ~PIO_MASK[2]) == '0)
        else $error("unimplemented line driven");
    genvar g;
    for (g = 0; g < PIO_NP; g++) begin : g_chk
        hiz_input_a: assert property ((pad[g].oe & ~$past(dir_r[g]) & ~$past(alt_r[g])) == '0)
            else $error("input line is driven");
        od_low_a: assert property ((pad[g].out & $past(od_r[g])) == '0)
            else $error("open-drain line driven high");
        alt_take_a: assert property ((pad[g].out & ~$past(od_r[g]) & $past(alt_r[g]) &
            $past(alt_oe[g])) == ($past(alt_out[g]) & ~$past(od_r[g]) & $past(alt_r[g]) &
            $past(alt_oe[g]) & PIO_MASK[g] & {PIO_W{PIO_CAP[g].io}}))
            else $error("alternate output not passed");
    end
endmodule // pio_ports

// >>> pio_pkg.sv
// Constants, types and helpers for the parallel port block.
// Assumes one APB slave clocked by pclk, ports laid out in 32-byte windows.
// Notes on behaviour
// - Six I/O ports, one input port, 79 lines.
// - Each line set, cleared, tested alone.
// - One direction bit per bidirectional line.
// - Input direction leaves pin undriven.
// - Per-pin push-pull or open-drain choice.
// - Reset makes pins inputs, except reset indication.
// - Driver shape and strength reach pads.
// - Per-byte TTL or hysteresis input threshold.
// - Alternate function may claim a line.
// - Input-only port has no pad controls.
// - Bus address/data ports: driver control only.
package pio_pkg;
    // Port count and line width
    localparam int PIO_NP = 7;
    localparam int PIO_W = 16;
    typedef logic [PIO_W-1:0] pio_word_t;
    typedef logic [2:0] pio_idx_t;
    // Register offsets inside one port window
    localparam logic [4:0] PIO_OFF_DATA = 5'h00;
    localparam logic [4:0] PIO_OFF_DIR = 5'h04;
    localparam logic [4:0] PIO_OFF_OD = 5'h08;
    localparam logic [4:0] PIO_OFF_ALT = 5'h0c;
    localparam logic [4:0] PIO_OFF_THR = 5'h10;
    localparam logic [4:0] PIO_OFF_SET = 5'h14;
    localparam logic [4:0] PIO_OFF_CLR = 5'h18;
    localparam logic [4:0] PIO_OFF_DRV = 5'h1c;
    // Port window select bits of paddr
    localparam int PIO_PORT_LSB = 5;
    // Reset values
    localparam pio_word_t PIO_RST_WORD = 16'h0000;
    localparam logic [1:0] PIO_RST_THR = 2'h0;
    // Implemented lines per port, 79 in total
    localparam pio_word_t PIO_MASK [PIO_NP] = '{16'hffff, 16'hffff, 16'h7fff, 16'h00ff,
                                               16'h3fff, 16'h003f, 16'h000f};
    // Control features of each port
    typedef struct packed {
        logic drv; // Pad driver shape/strength
        logic od;  // Open-drain select
        logic thr; // Threshold select
        logic io;  // Has output drivers
    } pio_cap_s;
    // Order: bus_addr_data_port, addr port, p3, p4, analog input port, p9, p20
    localparam pio_cap_s PIO_CAP [PIO_NP] = '{4'b1001, 4'b1001, 4'b1111, 4'b1111,
                                             4'b0000, 4'b1111, 4'b1101};
    // Index of the input-only port
    localparam pio_idx_t PIO_IN_PORT = 3'h4;
    // Pad drive of one port
    typedef struct packed {
        pio_word_t out; // Level driven when enabled
        pio_word_t oe;  // High while the pin is driven
    } pio_pad_s;
    // Read view: pin for inputs, latch for outputs
    function automatic pio_word_t pio_rd_mux(pio_word_t dir, pio_word_t pin, pio_word_t lat);
        return (pin & ~dir) | (lat & dir);
    endfunction
    // Byte threshold bits widened to lines
    function automatic pio_word_t pio_thr_lines(logic [1:0] thr);
        return {{8{thr[1]}}, {8{thr[0]}}};
    endfunction
endpackage

// >>> pio_board.sv
// Board circuitry model: resolves each pin from the pad drive and board levels.
// Assumes the bench sets board levels; a pad that drives always wins.
`timescale 1ns/1ps
module pio_board
    import pio_pkg::*;
(
    // Pad drive from the block
    input wire pio_pad_s [PIO_NP-1:0] pad,
    // Board pull or source level per line
    input wire logic [PIO_NP-1:0][PIO_W-1:0] ext_lvl,
    // Resolved pin levels
    output logic [PIO_NP-1:0][PIO_W-1:0] pin
);
    always_comb begin
        for (int p = 0; p < PIO_NP; p++) begin
            pin[p] = (pad[p].oe & pad[p].out) | (~pad[p].oe & ext_lvl[p]);
        end
    end
endmodule // pio_board

// >>> test_parallel_io_ports.sv
// Self-checking bench for the parallel port block against a port model.
// Assumes zero-wait APB and pads that settle two edges after a write.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module test_parallel_io_ports;
    import pio_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, rst_req, pready, pslverr, rio, rioe;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [PIO_NP-1:0][PIO_W-1:0] pin_in, alt_out, alt_oe, alt_in, drvc, thrc, ext_lvl;
    pio_pad_s [PIO_NP-1:0] pad;
    int fail_count = 0;
    int n_tests = 0;
    logic [15:0] lf = 16'h0038; // Random source state
    // Model registers per port
    logic [15:0] m_lat [PIO_NP], m_dir [PIO_NP], m_od [PIO_NP], m_alt [PIO_NP], m_drv [PIO_NP];
    logic [1:0] m_thr [PIO_NP];
    logic [31:0] r;
    logic e;
    pio_ports i_pio_ports (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .pad(pad), .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in), .pad_driver_shape_ctrl(drvc),
        .thr_cmos(thrc), .rst_req(rst_req), .reset_indication_out(rio), .reset_indication_oe(rioe));
    pio_board i_pio_board (.pad(pad), .ext_lvl(ext_lvl), .pin(pin_in));
    // Clock, 50 ns period
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // Shift register random step
    function automatic logic [15:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf;
    endfunction
    // One APB transfer; idles one cycle after so no signal is set twice in a step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Register write plus model update; lacking features store nothing
    task automatic wr(input int p, input logic [4:0] off, input logic [15:0] d);
        logic [15:0] m;
        m = PIO_MASK[p];
        apb(1'b1, {p[2:0], off}, {16'h0000, d}, r, e);
        case (off)
            PIO_OFF_DATA: m_lat[p] = d & m;
            PIO_OFF_SET: m_lat[p] = m_lat[p] | (d & m);
            PIO_OFF_CLR: m_lat[p] = m_lat[p] & ~d;
            PIO_OFF_DIR: m_dir[p] = PIO_CAP[p].io ? d & m : 16'h0000;
            PIO_OFF_OD: m_od[p] = PIO_CAP[p].od ? d & m : 16'h0000;
            PIO_OFF_ALT: m_alt[p] = d & m;
            PIO_OFF_THR: m_thr[p] = PIO_CAP[p].thr ? d[1:0] : 2'h0;
            default: m_drv[p] = PIO_CAP[p].drv ? d : 16'h0000;
        endcase
    endtask
    // Compare pads, config outputs and readback of one port with the model
    task automatic chk(input int p);
        logic [15:0] m, eoe, eout, epin;
        logic [4:0] offs [5];
        logic [31:0] ex [5];
        m = PIO_MASK[p];
        eoe = ((m_alt[p] & alt_oe[p]) | (~m_alt[p] & m_dir[p] & (~m_od[p] | ~m_lat[p]))) & m;
        eoe = PIO_CAP[p].io ? eoe : 16'h0000;
        eout = ((m_alt[p] & alt_out[p]) | (~m_alt[p] & m_lat[p] & ~m_od[p])) & eoe;
        epin = (eoe & eout) | (~eoe & ext_lvl[p]);
        offs = '{PIO_OFF_DATA, PIO_OFF_DIR, PIO_OFF_OD, PIO_OFF_THR, PIO_OFF_DRV};
        ex = '{{16'h0000, ((epin & ~m_dir[p]) | (m_lat[p] & m_dir[p])) & m}, {16'h0000, m_dir[p]},
               {16'h0000, m_od[p]}, {30'h0, m_thr[p]}, {16'h0000, m_drv[p]}};
        repeat (3) @(posedge pclk);
        `CHK("pad_oe", eoe, pad[p].oe)
        `CHK("pad_out", eout, pad[p].out)
        `CHK("alt_in", epin & m, alt_in[p] & m)
        `CHK("drv_out", m_drv[p], drvc[p])
        `CHK("thr_out", {{8{m_thr[p][1]}}, {8{m_thr[p][0]}}} & m, thrc[p] & m)
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, {p[2:0], offs[i]}, 32'h0, r, e);
            `CHK("readback", ex[i], r)
        end
    endtask
    // Verdict and end of run
    task automatic test_done();
        $display("counts: %0d checks, %0d mismatches", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Watchdog, well above the expected several hundred cycles
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        test_done();
    end
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, rst_req, paddr, pwdata} = '0;
        {alt_out, alt_oe, ext_lvl} = '0;
        for (int p = 0; p < PIO_NP; p++) begin
            {m_lat[p], m_dir[p], m_od[p], m_alt[p], m_drv[p], m_thr[p]} = '0;
        end
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values everywhere
        for (int p = 0; p < PIO_NP; p++) chk(p);
        $display("test reset_values done");
        // Random setup, then single-bit set and clear, per port
        for (int p = 0; p < PIO_NP; p++) begin
            ext_lvl[p] <= rnd();
            wr(p, PIO_OFF_DIR, rnd());
            wr(p, PIO_OFF_OD, rnd());
            wr(p, PIO_OFF_DATA, rnd());
            wr(p, PIO_OFF_THR, rnd());
            wr(p, PIO_OFF_DRV, rnd());
            chk(p);
            wr(p, PIO_OFF_SET, 16'h0001 << (rnd() % 16));
            wr(p, PIO_OFF_CLR, 16'h0001 << (rnd() % 16));
            chk(p);
        end
        $display("test port_config done");
        // Missing window and misaligned address are refused, nothing changes
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, i ? 8'h02 : 8'he0, 32'hffffffff, r, e);
            `CHK("werr", 1'b1, e)
            apb(1'b0, i ? 8'h02 : 8'he0, 32'h0, r, e);
            `CHK("rdata_bad", 32'h0, r)
        end
        chk(0);
        $display("test refused done");
        // Peripheral claims lines; the input-only port still never drives
        wr(2, PIO_OFF_OD, 16'h0000);
        alt_out[2] <= rnd();
        alt_oe[2] <= rnd();
        alt_oe[4] <= 16'hffff;
        wr(2, PIO_OFF_ALT, 16'hffff);
        wr(4, PIO_OFF_ALT, 16'hffff);
        chk(2);
        chk(4);
        $display("test alternate done");
        // Reset indication pin and a second reset mid-run
        rst_req <= 1'b1;
        repeat (3) @(posedge pclk);
        `CHK("rst_ind_low", 2'b01, {rio, rioe})
        rst_req <= 1'b0;
        repeat (3) @(posedge pclk);
        `CHK("rst_ind_high", 1'b1, rio)
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        for (int p = 0; p < PIO_NP; p++) `CHK("oe_in_reset", 16'h0000, pad[p].oe)
        `CHK("rst_ind_oe", 1'b1, rioe)
        // Release again: indication rises, configuration is back to reset values
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        `CHK("rst_ind_rel", 1'b1, rio)
        `CHK("oe_after_rel", 16'h0000, pad[2].oe)
        apb(1'b0, {3'h2, PIO_OFF_DIR}, 32'h0, r, e);
        `CHK("dir_after_rel", 32'h0, r)
        $display("test reset_mid done");
        test_done();
    end
endmodule // test_parallel_io_ports
